// ===== smu_pkg.sv
// Constants, register map and types of the signed multiply unit
package smu_pkg;

   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int CLK_MHZ  = 200;
   localparam int SCAN_NS  = 1000;
   localparam int SCAN_CYC = (SCAN_NS * CLK_MHZ + 999) / 1000;
   localparam int SCAN_W   = $clog2(SCAN_CYC);

   // -------------------------------------------------------------
   // Register map (byte addresses)
   // -------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_CTRL  = 8'h00;
   localparam logic [7:0] OFF_SRC_A = 8'h04;
   localparam logic [7:0] OFF_SRC_B = 8'h08;
   localparam logic [7:0] OFF_STAT  = 8'h0c;
   localparam logic [7:0] OFF_ISTAT = 8'h10;
   localparam logic [7:0] OFF_IMASK = 8'h14;
   localparam logic [7:0] OFF_RES0  = 8'h18;
   localparam logic [7:0] OFF_RES1  = 8'h1c;
   localparam logic [7:0] OFF_RES2  = 8'h20;
   localparam logic [7:0] OFF_RES3  = 8'h24;

   // Control word fields
   localparam int CB_EXEC  = 0;
   localparam int CB_VAR   = 1;
   localparam int CB_FLOAT = 3;
   localparam int CB_INDEX = 4;
   localparam int CB_DIG   = 5;
   localparam int CB_AFMT  = 9;
   localparam int CB_BFMT  = 11;
   localparam int CTRL_W   = 13;
   localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;

   // Status and interrupt bits
   localparam int SB_ZERO  = 0;
   localparam int SB_EXEC  = 1;
   localparam int IB_DONE  = 0;
   localparam int IB_REJ   = 1;
   localparam int IRQ_W    = 2;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Number formats
   localparam int BCD_DIGITS = 7;
   localparam int DEC_SIGN   = 31;
   localparam logic [7:0] F_BIAS = 8'h7f;
   localparam logic [9:0] F_EMAX = 10'h0ff;

   typedef enum logic [1:0] {
      SMU_MUL16_SINGLE_SHOT = 2'h0,
      SMU_MUL32_CONTINUOUS  = 2'h1,
      SMU_MUL32_SINGLE_SHOT = 2'h2
   } smu_variant_e;

   typedef enum logic [1:0] {
      SMU_SRC_WORD = 2'h0,
      SMU_SRC_DEC  = 2'h1,
      SMU_SRC_HEX  = 2'h2
   } smu_fmt_e;

   typedef enum logic [1:0] {
      SMU_IDLE = 2'b00,
      SMU_CALC = 2'b01
   } smu_state_e;

endpackage

// ===== smu_mul_if.sv
// Request and answer between the sequencer and the multiply core
`timescale 1ns/1ps
`default_nettype none
interface smu_mul_if;
   logic        req;      // One-cycle start
   logic        is_float; // Float multiply instead of integer
   logic [31:0] opa;      // Prepared operand a
   logic [31:0] opb;      // Prepared operand b
   logic        done;     // One-cycle answer
   logic [63:0] prod;     // Product, float in low word

   modport ctl  (output req, is_float, opa, opb, input done, prod);
   modport core (input req, is_float, opa, opb, output done, prod);
endinterface
`default_nettype wire

// ===== smu_mul_core.sv
// Signed integer and binary float multiply core, one cycle
`timescale 1ns/1ps
`default_nettype none
module smu_mul_core (
   input  wire logic aclk,    // Clock
   input  wire logic aresetn, // Sync reset, active low
   smu_mul_if.core   mul      // Operands and product
);
   // -------------------------------------------------------------
   // Float multiply
   // -------------------------------------------------------------
   // Zero or denormal inputs flush to zero, even against inf/nan;
   // other inf/nan inputs give inf; fields
   // are truncated, not rounded, to keep the path short.
   function automatic logic [31:0] fmul(input logic [31:0] a,
                                        input logic [31:0] b);
      logic        s;
      logic [47:0] p;
      logic [9:0]  e;
      logic [22:0] m;
      s = a[31] ^ b[31];
      p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
      e = 10'(a[30:23]) + 10'(b[30:23]) - 10'(smu_pkg::F_BIAS);
      m = p[45:23];
      if (p[47]) begin
         e = e + 10'h001;
         m = p[46:24];
      end
      if (a[30:23] == 8'h00 || b[30:23] == 8'h00) begin
         fmul = {s, 31'h0000_0000};
      end else if (a[30:23] == 8'hff || b[30:23] == 8'hff ||
                   (!e[9] && e >= smu_pkg::F_EMAX)) begin
         fmul = {s, 8'hff, 23'h000000};
      end else if (e[9] || e == 10'h000) begin
         fmul = {s, 31'h0000_0000};
      end else begin
         fmul = {s, e[7:0], m};
      end
   endfunction

   // -------------------------------------------------------------
   // Product register
   // -------------------------------------------------------------
   wire logic [63:0] int_prod;
   wire logic [63:0] flt_prod;
   assign int_prod = 64'($signed(mul.opa) * $signed(mul.opb));
   assign flt_prod = {32'h0000_0000, fmul(mul.opa, mul.opb)};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mul.done <= 1'b0;
         mul.prod <= 64'h0;
      end else begin
         mul.done <= mul.req;
         if (mul.req) begin
            mul.prod <= mul.is_float ? flt_prod : int_prod;
         end
      end
   end
endmodule
`default_nettype wire

// ===== smu_top.sv
// Signed multiply unit: register slave, firing control, operand prep
//
// How it works
// - Word mode: 16x16 product, low half to result word 0, high to word 1.
// - Operands and product are two's-complement signed, sign in top bit.
// - A decimal constant source is turned into binary before multiplying.
// - Word mode with 1 to 8 nibbles keeps only low 4n product bits.
// - Double-word mode: 32x32 product over four words, low word first.
// - Double-word with nibble destination keeps low 4n bits, drops high.
// - Zero flag set when the product is zero, cleared otherwise.
// - Float select makes double-word multiply a binary float multiply.
// - In float mode constants are converted to float; words used as-is.
// - Indexed destination allowed for word multiply, rejected for double.
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module smu_top (
   input  wire logic                      aclk,              // Clock, 200 MHz
   input  wire logic                      aresetn,           // Sync reset, low
   input  wire logic [smu_pkg::ADDR_W-1:0] s_axi_awaddr,     // Write address
   input  wire logic                      s_axi_awvalid,     // Write addr valid
   output logic                           s_axi_awready,     // Write addr ready
   input  wire logic [31:0]               s_axi_wdata,       // Write data
   input  wire logic [3:0]                s_axi_wstrb,       // Byte enables
   input  wire logic                      s_axi_wvalid,      // Write data valid
   output logic                           s_axi_wready,      // Write data ready
   output logic [1:0]                     s_axi_bresp,       // Write response
   output logic                           s_axi_bvalid,      // Response valid
   input  wire logic                      s_axi_bready,      // Response ready
   input  wire logic [smu_pkg::ADDR_W-1:0] s_axi_araddr,     // Read address
   input  wire logic                      s_axi_arvalid,     // Read addr valid
   output logic                           s_axi_arready,     // Read addr ready
   output logic [31:0]                    s_axi_rdata,       // Read data
   output logic [1:0]                     s_axi_rresp,       // Read response
   output logic                           s_axi_rvalid,      // Read data valid
   input  wire logic                      s_axi_rready,      // Read data ready
   output logic                           zero_result_flag,  // Last product zero
   output logic                           exec_state,        // Execution state
   output logic                           irq                // Level interrupt
);

   // -------------------------------------------------------------
   // Conversion helpers
   // -------------------------------------------------------------
   // Decimal constant: sign in bit 31, seven BCD digits below
   function automatic logic [31:0] bcd2bin(input logic [31:0] v);
      logic [31:0] acc;
      acc = 32'h0;
      for (int i = smu_pkg::BCD_DIGITS - 1; i >= 0; i--) begin
         acc = 32'(acc * 32'd10) + 32'(v[4*i +: 4]);
      end
      bcd2bin = v[smu_pkg::DEC_SIGN] ? 32'(-acc) : acc;
   endfunction

   // Signed integer to float, mantissa truncated
   function automatic logic [31:0] int2flt(input logic [31:0] v);
      logic [31:0] mag;
      logic [31:0] nrm;
      logic [4:0]  msb;
      mag = v[31] ? 32'(-v) : v;
      msb = 5'h00;
      for (int i = 0; i < 32; i++) begin
         if (mag[i]) begin
            msb = 5'(i);
         end
      end
      nrm = mag << (5'd31 - msb);
      if (mag == 32'h0) begin
         int2flt = 32'h0;
      end else begin
         int2flt = {v[31], 8'(smu_pkg::F_BIAS + 8'(msb)), nrm[30:8]};
      end
   endfunction

   // Source as seen by the multiplier
   function automatic logic [31:0] prep(input logic [31:0] v,
                                        input logic [1:0]  fmt,
                                        input logic        op32,
                                        input logic        flt);
      logic [31:0] bin;
      bin = (fmt == smu_pkg::SMU_SRC_DEC) ? bcd2bin(v) : v;
      if (flt) begin
         prep = (fmt == smu_pkg::SMU_SRC_WORD) ? v : int2flt(bin);
      end else if (op32) begin
         prep = bin;
      end else begin
         prep = {{16{bin[15]}}, bin[15:0]};
      end
   endfunction

   // Keeps 4n low bits for a nibble-group destination
   function automatic logic [31:0] nib_mask(input logic [3:0] n);
      logic [31:0] m;
      m = 32'h0;
      for (int i = 0; i < 8; i++) begin
         if (4'(i) < n) begin
            m[4*i +: 4] = 4'hf;
         end
      end
      nib_mask = m;
   endfunction

   function automatic logic [31:0] wmerge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      wmerge = r;
   endfunction

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   logic [smu_pkg::CTRL_W-1:0] ctrl_q;
   logic [31:0]                src_a_q;
   logic [31:0]                src_b_q;
   logic [15:0]                res_q [4];
   logic [smu_pkg::IRQ_W-1:0]  istat_q;
   logic [smu_pkg::IRQ_W-1:0]  imask_q;
   logic [smu_pkg::SCAN_W-1:0] scan_cnt_q;
   logic                       cond_prev_q;
   smu_pkg::smu_state_e        state_q;
   logic                       calc_op32_q;
   logic                       calc_flt_q;
   logic [3:0]                 calc_dig_q;

   smu_mul_if mul ();

   smu_mul_core u_core (
      .aclk    (aclk),
      .aresetn (aresetn),
      .mul     (mul)
   );

   // -------------------------------------------------------------
   // Control decode
   // -------------------------------------------------------------
   wire logic       cond;
   wire logic [1:0] variant;
   wire logic       flt_sel;
   wire logic       dst_index;
   wire logic [3:0] digits;
   wire logic [1:0] afmt;
   wire logic [1:0] bfmt;
   wire logic       op32;
   wire logic       single;
   wire logic       bad_var;
   wire logic       reject;
   wire logic       scan_tick;
   wire logic       fire;

   assign cond      = ctrl_q[smu_pkg::CB_EXEC];
   assign variant   = ctrl_q[smu_pkg::CB_VAR +: 2];
   assign flt_sel   = ctrl_q[smu_pkg::CB_FLOAT];
   assign dst_index = ctrl_q[smu_pkg::CB_INDEX];
   assign digits    = ctrl_q[smu_pkg::CB_DIG +: 4];
   assign afmt      = ctrl_q[smu_pkg::CB_AFMT +: 2];
   assign bfmt      = ctrl_q[smu_pkg::CB_BFMT +: 2];
   assign op32      = (variant != smu_pkg::SMU_MUL16_SINGLE_SHOT);
   assign single    = (variant != smu_pkg::SMU_MUL32_CONTINUOUS);
   // Code 3 has no instruction behind it, so it is refused too
   assign bad_var   = (variant == 2'h3);
   assign reject    = bad_var || (op32 && dst_index);
   assign scan_tick = (scan_cnt_q == smu_pkg::SCAN_W'(smu_pkg::SCAN_CYC - 1));
   // Condition is only sampled once per scan, like a program scan
   assign fire      = scan_tick && cond &&
                      (!single || !cond_prev_q);

   assign mul.req      = fire && !reject && (state_q == smu_pkg::SMU_IDLE);
   assign mul.is_float = op32 && flt_sel;
   assign mul.opa      = prep(src_a_q, afmt, op32, mul.is_float);
   assign mul.opb      = prep(src_b_q, bfmt, op32, mul.is_float);

   // -------------------------------------------------------------
   // Result shaping
   // -------------------------------------------------------------
   wire logic [31:0] low_kept;
   wire logic        prod_zero;

   assign low_kept  = (calc_dig_q == 4'h0) ? mul.prod[31:0] :
                      (mul.prod[31:0] & nib_mask(calc_dig_q));
   assign prod_zero = calc_flt_q ? (mul.prod[30:0] == 31'h0) :
                      (mul.prod == 64'h0);

   // -------------------------------------------------------------
   // Scan divider and sequencing
   // -------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scan_cnt_q  <= '0;
         cond_prev_q <= 1'b0;
         exec_state  <= 1'b0;
      end else begin
         scan_cnt_q <= scan_tick ? '0 : scan_cnt_q + 1'b1;
         if (scan_tick) begin
            cond_prev_q <= cond;
            exec_state  <= cond && !reject;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q          <= smu_pkg::SMU_IDLE;
         calc_op32_q      <= 1'b0;
         calc_flt_q       <= 1'b0;
         calc_dig_q       <= 4'h0;
         zero_result_flag <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            res_q[i] <= 16'h0000;
         end
      end else begin
         unique case (state_q)
            smu_pkg::SMU_IDLE: begin
               if (mul.req) begin
                  state_q     <= smu_pkg::SMU_CALC;
                  calc_op32_q <= op32;
                  calc_flt_q  <= mul.is_float;
                  calc_dig_q  <= digits;
               end
            end
            smu_pkg::SMU_CALC: begin
               if (mul.done) begin
                  state_q          <= smu_pkg::SMU_IDLE;
                  zero_result_flag <= prod_zero;
                  res_q[0]         <= low_kept[15:0];
                  res_q[1]         <= low_kept[31:16];
                  // High words only for a full double-word integer result
                  if (calc_op32_q && !calc_flt_q && calc_dig_q == 4'h0) begin
                     res_q[2] <= mul.prod[47:32];
                     res_q[3] <= mul.prod[63:48];
                  end
               end
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // Interrupt events
   // -------------------------------------------------------------
   wire logic [smu_pkg::IRQ_W-1:0] ev;
   assign ev[smu_pkg::IB_DONE] = (state_q == smu_pkg::SMU_CALC) && mul.done;
   assign ev[smu_pkg::IB_REJ]  = fire && reject;

   // -------------------------------------------------------------
   // AXI4-Lite slave
   // -------------------------------------------------------------
   wire logic wr_go;
   wire logic rd_go;
   wire logic wr_hit;
   wire logic rd_hit;
   wire logic [31:0] rd_val;
   wire logic [31:0] wdat;

   assign wr_go = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
   assign rd_go = s_axi_arvalid && s_axi_arready;
   assign wdat  = s_axi_wdata;

   function automatic logic mapped(input logic [smu_pkg::ADDR_W-1:0] a);
      unique case (a)
         smu_pkg::OFF_CTRL, smu_pkg::OFF_SRC_A, smu_pkg::OFF_SRC_B,
         smu_pkg::OFF_STAT, smu_pkg::OFF_ISTAT, smu_pkg::OFF_IMASK,
         smu_pkg::OFF_RES0, smu_pkg::OFF_RES1, smu_pkg::OFF_RES2,
         smu_pkg::OFF_RES3: mapped = 1'b1;
         default:           mapped = 1'b0;
      endcase
   endfunction

   assign wr_hit = mapped(s_axi_awaddr);
   assign rd_hit = mapped(s_axi_araddr);
   assign rd_val =
      (s_axi_araddr == smu_pkg::OFF_CTRL)  ? 32'(ctrl_q) :
      (s_axi_araddr == smu_pkg::OFF_SRC_A) ? src_a_q :
      (s_axi_araddr == smu_pkg::OFF_SRC_B) ? src_b_q :
      (s_axi_araddr == smu_pkg::OFF_STAT)  ?
         32'({exec_state, zero_result_flag}) :
      (s_axi_araddr == smu_pkg::OFF_ISTAT) ? 32'(istat_q) :
      (s_axi_araddr == smu_pkg::OFF_IMASK) ? 32'(imask_q) :
      (s_axi_araddr == smu_pkg::OFF_RES0)  ? 32'(res_q[0]) :
      (s_axi_araddr == smu_pkg::OFF_RES1)  ? 32'(res_q[1]) :
      (s_axi_araddr == smu_pkg::OFF_RES2)  ? 32'(res_q[2]) :
      (s_axi_araddr == smu_pkg::OFF_RES3)  ? 32'(res_q[3]) : 32'h0;

   // Write channel takes address and data together, one at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= smu_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                          !s_axi_bvalid;
         s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                          !s_axi_bvalid;
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? smu_pkg::RESP_OKAY : smu_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= smu_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_hit ? smu_pkg::RESP_OKAY : smu_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------
   // Software registers
   // -------------------------------------------------------------
   wire logic [31:0] ctrl_w;
   assign ctrl_w = wmerge(32'(ctrl_q), wdat, s_axi_wstrb);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q  <= smu_pkg::CTRL_RST;
         src_a_q <= 32'h0;
         src_b_q <= 32'h0;
         imask_q <= '0;
      end else if (wr_go) begin
         if (s_axi_awaddr == smu_pkg::OFF_CTRL) begin
            ctrl_q <= ctrl_w[smu_pkg::CTRL_W-1:0];
         end
         if (s_axi_awaddr == smu_pkg::OFF_SRC_A) begin
            src_a_q <= wmerge(src_a_q, wdat, s_axi_wstrb);
         end
         if (s_axi_awaddr == smu_pkg::OFF_SRC_B) begin
            src_b_q <= wmerge(src_b_q, wdat, s_axi_wstrb);
         end
         if (s_axi_awaddr == smu_pkg::OFF_IMASK && s_axi_wstrb[0]) begin
            imask_q <= wdat[smu_pkg::IRQ_W-1:0];
         end
      end
   end

   // Sticky status: a new event wins over a same-cycle clear
   wire logic [smu_pkg::IRQ_W-1:0] w1c;
   assign w1c = (wr_go && s_axi_awaddr == smu_pkg::OFF_ISTAT &&
                 s_axi_wstrb[0]) ? wdat[smu_pkg::IRQ_W-1:0] : '0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         istat_q <= '0;
         irq     <= 1'b0;
      end else begin
         istat_q <= (istat_q & ~w1c) | ev;
         irq     <= |(((istat_q & ~w1c) | ev) & imask_q);
      end
   end

endmodule
`default_nettype wire

// ===== smu_top_monitor.sv
// Port-level assertions of the signed multiply unit
`timescale 1ns/1ps
`default_nettype none
module smu_top_monitor (
   input wire logic        aclk, aresetn, irq, exec_state, zero_result_flag, // Core
   input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wready, // Write request
   input wire logic        s_axi_bvalid, s_axi_bready, s_axi_rvalid, s_axi_rready, // Answers
   input wire logic        s_axi_arvalid, s_axi_arready, // Read request
   input wire logic [1:0]  s_axi_bresp, // Write response
   input wire logic [31:0] s_axi_rdata  // Read data
);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   wire logic aw_hs = s_axi_awvalid && s_axi_awready;
   wire logic ar_hs = s_axi_arvalid && s_axi_arready;
   // Cycles since each flag last moved; both may only move once per scan
   logic [7:0] ex_q, zr_q;
   logic       ex_p_q, zr_p_q;
   always_ff @(posedge aclk) begin
      ex_p_q <= exec_state;
      zr_p_q <= zero_result_flag;
      ex_q   <= (!aresetn || ex_p_q != exec_state) ? 8'h00 : ex_q + {7'h00, ~&ex_q};
      zr_q   <= (!aresetn || zr_p_q != zero_result_flag) ? 8'h00 : zr_q + {7'h00, ~&zr_q};
   end
   a_exec_on_scan: assert property (ex_p_q != exec_state |-> ex_q >= 8'hc0)
      else $error("exec state moved between scans");
   a_zero_on_scan: assert property (zr_p_q != zero_result_flag |-> zr_q >= 8'hc0)
      else $error("zero flag moved between scans");
   a_write_answer: assert property (aw_hs |=> s_axi_bvalid) else $error("no write response");
   a_read_answer: assert property (ar_hs |=> s_axi_rvalid) else $error("no read data");
   a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   a_ready_pulse: assert property (s_axi_awready |-> s_axi_wready ##1 !s_axi_awready)
      else $error("ready not a paired pulse");
   a_reset_quiet: assert property ($rose(aresetn) |-> !irq && !exec_state && !zero_result_flag)
      else $error("flags up after reset");
   a_irq_clear: assert property ($fell(irq) |-> $past(aw_hs) || $past(aw_hs, 2))
      else $error("interrupt fell without a write");
   c_irq: cover property ($rose(irq));
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   c_exec: cover property ($rose(exec_state));
endmodule
bind smu_top smu_top_monitor u_mon (.*);
`default_nettype wire

// ===== smu_seq_model.sv
// Sequencer model that sets up multiplies over the register bus
`timescale 1ns/1ps
`default_nettype none
module smu_seq_model (
   input  wire logic        aclk, s_axi_awready, s_axi_bvalid, s_axi_arready, // Answers
   input  wire logic        s_axi_rvalid, // Read valid
   input  wire logic [1:0]  s_axi_bresp, s_axi_rresp, // Responses
   input  wire logic [31:0] s_axi_rdata, // Read data
   output logic      [7:0]  s_axi_awaddr, s_axi_araddr, // Addresses
   output logic      [31:0] s_axi_wdata, // Write data
   output logic      [3:0]  s_axi_wstrb, // Byte enables
   output logic             s_axi_awvalid, s_axi_wvalid, s_axi_bready, // Write strobes
   output logic             s_axi_arvalid, s_axi_rready // Read strobes
);
   wire logic [3:0] hs = {s_axi_rvalid, s_axi_arready, s_axi_bvalid, s_axi_awready};
   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
   end
   // A silent slave ends the run instead of hanging it
   task automatic wt(input int k);
      for (int i = 0; i < 64; i++) begin
         @(posedge aclk);
         if (hs[k] === 1'b1) return;
      end
      tb_signed_multiply_unit.hang();
   endtask
   // Released payload is inverted so a stale value cannot pass for a held one
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid} <= {a, d, 6'h3f};
      wt(0);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {~a, ~d, 3'h1};
      wt(1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
      wt(2);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {~a, 2'h1};
      wt(3);
      {r, d} = {s_axi_rresp, s_axi_rdata};
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
endmodule
`default_nettype wire

// ===== tb_signed_multiply_unit.sv
// Self-checking bench of the signed multiply unit
`timescale 1ns/1ps
`default_nettype none
module tb_signed_multiply_unit;
   logic        aclk, aresetn, irq, exec_state, zero_result_flag, s_axi_wvalid, s_axi_wready;
   logic        s_axi_awvalid, s_axi_awready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv, a, b, ist, sta;
   logic [63:0] p, ex, m;
   logic [12:0] c;
   int          n_fail, n_compared;
   smu_top DUT (.*);
   smu_seq_model u_seq (.*);
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("compared %0d, wrong %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic hang();
      n_fail++;
      give_verdict();
   endtask
   task automatic w(input logic [7:0] ad, input logic [31:0] d);
      u_seq.wr(ad, d, rs);
   endtask
   task automatic r(input logic [7:0] ad);
      u_seq.rd(ad, rv, rs);
   endtask
   task automatic wirq();
      for (int i = 0; i < 500 && irq !== 1'b1; i++) @(posedge aclk);
      if (irq !== 1'b1) hang();
   endtask
   // One firing; the condition drops for a full scan so the next rise is seen
   task automatic run(input logic [12:0] cw);
      w(smu_pkg::OFF_SRC_A, a);
      w(smu_pkg::OFF_SRC_B, b);
      w(smu_pkg::OFF_CTRL, {19'h0, cw | 13'h0001});
      wirq();
      for (int k = 0; k < 4; k++) begin
         r(smu_pkg::OFF_RES0 + 8'(4 * k));
         p[16*k +: 16] = rv[15:0];
      end
      u_seq.rd(smu_pkg::OFF_ISTAT, ist, rs);
      u_seq.rd(smu_pkg::OFF_STAT, sta, rs);
      w(smu_pkg::OFF_CTRL, {19'h0, cw});
      repeat (210) @(posedge aclk);
      w(smu_pkg::OFF_ISTAT, 32'h3);
   endtask
   initial begin
      n_fail = 0;
      n_compared = 0;
      aresetn = 1'b0;
      void'($urandom(82));
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      r(smu_pkg::OFF_CTRL);
      chk(rv, 32'h0);
      w(smu_pkg::OFF_IMASK, 32'h3);
      for (int t = 0; t < 9; t++) begin
         a = $urandom;
         b = (t == 0) ? 32'h0 : $urandom;
         c = {4'h0, 4'($urandom_range(8)), 1'($urandom), 1'b0, 2'(t % 3), 1'b0};
         if (c[2:1] != 2'h0) c[8:4] = (t > 4) ? 5'h10 : 5'h00;
         ex = (c[2:1] == 2'h0) ? longint'($signed(a[15:0])) * longint'($signed(b[15:0]))
                               : longint'($signed(a)) * longint'($signed(b));
         m = (c[8:5] != 4'h0) ? (64'h1 << (4 * c[8:5])) - 64'h1 : 64'hffffffff;
         if (c[8:5] == 4'h0 && c[2:1] != 2'h0) m = '1;
         run(c);
         chk(p & (m | 64'hffffffff), ex & m);
         chk(sta[1:0], {1'b1, ex == 64'h0});
         chk({exec_state, zero_result_flag}, {1'b0, ex == 64'h0});
      end
      $display("random products done");
      a = 32'h80000053;
      b = 32'd15;
      run(13'h0200);
      chk(p[31:0], 32'hfffffce5);
      a = 32'h00000053;
      run(13'h0240);
      chk(p[7:0], 8'h1b);
      a = 32'h40000000;
      b = 32'h40400000;
      run(13'h000c);
      chk(p[31:0], 32'h40c00000);
      a = 32'h00000002;
      run(13'h040c);
      chk(p[31:0], 32'h40c00000);
      $display("constant and float products done");
      for (int k = 0; k < 2; k++) begin
         run((k == 0) ? 13'h0014 : 13'h0006);
         chk({ist[1:0], sta[1]}, 3'h4);
      end
      $display("refused products done");
      w(smu_pkg::OFF_IMASK, 32'h0);
      w(smu_pkg::OFF_CTRL, 32'h3);
      repeat (420) @(posedge aclk);
      chk(irq, 1'b0);
      r(smu_pkg::OFF_ISTAT);
      chk(rv, 32'h1);
      w(smu_pkg::OFF_ISTAT, 32'h1);
      w(smu_pkg::OFF_IMASK, 32'h3);
      wirq();
      r(smu_pkg::OFF_ISTAT);
      chk(rv, 32'h1);
      w(smu_pkg::OFF_CTRL, 32'h1);
      w(smu_pkg::OFF_ISTAT, 32'h3);
      repeat (450) @(posedge aclk);
      chk(irq, 1'b0);
      w(smu_pkg::OFF_CTRL, 32'h0);
      $display("firing and interrupt done");
      w(8'h40, 32'h1);
      chk(rs, 2'h2);
      r(8'h40);
      chk({rs, rv}, {2'h2, 32'h0});
      $display("unmapped access done");
      give_verdict();
   end
endmodule
`default_nettype wire
